/* File: pfpc_top.sv */
`timescale 1ns/10ps
// Behaviour
// - Per-pin function field selects exactly one peripheral for the pin.
// - Analog function disables the pin's digital input and output paths.
// - Per-pin pull setting: pull-up, pull-down or repeater.
// - Per-pin pseudo open-drain output mode.
// - Switchable short glitch filter on some pins, on after reset.
// - Every pin has a digital filter with programmable constant.
// - Crystal use of a pin disables its digital pad section.
// - Fast-mode-plus pins are open-drain for every function.
// - Reset pin inactive in deep power-down; wake pin resets instead.
// - Wake pin function may be disabled when RTC wakes the chip.
module pfpc_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Per-pin configuration
  input wire logic [pfpc_pkg::NUM_PINS*pfpc_pkg::FSEL_W-1:0] func_sel,
  input wire logic [2*pfpc_pkg::NUM_PINS-1:0] pull_sel,
  input wire logic [pfpc_pkg::NUM_PINS-1:0] od_en,
  input wire logic [pfpc_pkg::NUM_PINS-1:0] glitch_en_wr,
  input wire logic [pfpc_pkg::NUM_PINS-1:0] glitch_en_val,
  input wire logic [pfpc_pkg::NUM_PINS-1:0] filt_en,
  input wire logic [pfpc_pkg::NUM_PINS*pfpc_pkg::FILT_W-1:0] filt_const,
  input wire logic [pfpc_pkg::NUM_PINS-1:0] xtal_en,
  // Peripheral side
  input wire logic [pfpc_pkg::NUM_PINS*pfpc_pkg::NUM_FUNCS-1:0] periph_out,
  input wire logic [pfpc_pkg::NUM_PINS*pfpc_pkg::NUM_FUNCS-1:0] periph_oe,
  output logic [pfpc_pkg::NUM_PINS*pfpc_pkg::NUM_FUNCS-1:0] periph_in,
  // Pads
  input wire logic [pfpc_pkg::NUM_PINS-1:0] pad_in,
  output logic [pfpc_pkg::NUM_PINS-1:0] pad_out,
  output logic [pfpc_pkg::NUM_PINS-1:0] pad_oe_n,
  output logic [pfpc_pkg::NUM_PINS-1:0] pad_pull_up,
  output logic [pfpc_pkg::NUM_PINS-1:0] pad_pull_down,
  output logic [pfpc_pkg::NUM_PINS-1:0] pad_digital_off,
  output logic [pfpc_pkg::NUM_PINS-1:0] glitch_en,
  // Power-down reset and wake
  input wire logic deep_pd,
  input wire logic rtc_wake_en,
  input wire logic wake_pin_disable,
  input wire logic reset_pin_n,
  output logic chip_reset_req,
  output logic wake_req
);
  import pfpc_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [NUM_PINS-1:0] sync1_ff;
  logic [NUM_PINS-1:0] sync2_ff;
  logic [1:0] rst_sync_ff;
  logic rst_pin_n;

  always_ff @(posedge clock) begin
    sync1_ff <= pad_in;
  end

  always_ff @(posedge clock) begin
    sync2_ff <= sync1_ff;
  end

  always_ff @(posedge clock) begin
    rst_sync_ff <= {rst_sync_ff[0], reset_pin_n};
  end

  assign rst_pin_n = rst_sync_ff[1];

  // ==========================================================
  // Per-pin logic
  logic [NUM_PINS-1:0] filt_q;
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // ======================================================
      // Pin kind
      logic glitch_pin;
      logic xtal_pin;
      logic fmp_pin;

      assign glitch_pin = GLITCH_PINS[g];
      assign xtal_pin = XTAL_PINS[g];
      assign fmp_pin = FMP_PINS[g];

      // ======================================================
      // Configuration decode
      logic [FSEL_W-1:0] fsel;
      logic [FILT_W-1:0] fconst;
      logic [1:0] pull;
      logic analog;
      logic xtal;
      logic dig_off;

      assign fsel = func_sel[g*FSEL_W +: FSEL_W];
      assign fconst = filt_const[g*FILT_W +: FILT_W];
      assign pull = pull_sel[2*g +: 2];
      assign analog = (fsel == FUNC_ANALOG);
      assign xtal = xtal_en[g] & xtal_pin;
      assign dig_off = analog | xtal;

      // ======================================================
      // Output path
      logic sel_out;
      logic sel_oe;
      logic open_drain;
      logic drive_en;
      logic nxt_out;
      logic nxt_oe_n;
      logic out_ff;
      logic oe_n_ff;
      logic dig_off_ff;

      assign sel_out = periph_out[g*NUM_FUNCS + fsel];
      assign sel_oe = periph_oe[g*NUM_FUNCS + fsel] & ~dig_off;
      assign open_drain = od_en[g] | fmp_pin;
      // Open drain only ever drives a low level
      assign drive_en = sel_oe & (~open_drain | ~sel_out);
      assign nxt_out = sel_out & ~open_drain & ~dig_off;
      assign nxt_oe_n = ~drive_en;

      always_ff @(posedge clock) begin
        if (reset) begin
          out_ff <= 1'b0;
        end else begin
          out_ff <= nxt_out;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          oe_n_ff <= 1'b1;
        end else begin
          oe_n_ff <= nxt_oe_n;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          dig_off_ff <= 1'b0;
        end else begin
          dig_off_ff <= dig_off;
        end
      end

      // ======================================================
      // Pull path
      logic nxt_pull_up;
      logic nxt_pull_down;
      logic pull_up_ff;
      logic pull_down_ff;

      assign nxt_pull_up = ~dig_off & pull[1];
      assign nxt_pull_down = ~dig_off & pull[0];

      always_ff @(posedge clock) begin
        if (reset) begin
          pull_up_ff <= 1'b0;
        end else begin
          pull_up_ff <= nxt_pull_up;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          pull_down_ff <= 1'b0;
        end else begin
          pull_down_ff <= nxt_pull_down;
        end
      end

      // ======================================================
      // Glitch filter
      logic glitch_ff;
      logic nxt_glitch;
      logic prev_ff;
      logic filt_ff;
      logic now_lvl;
      logic vote_lvl;
      logic raw;

      assign now_lvl = sync2_ff[g];
      // A single-sample spike is outvoted by the held level
      assign vote_lvl = (now_lvl & prev_ff) | (filt_ff & (now_lvl | prev_ff));
      assign raw = (glitch_ff & glitch_pin) ? vote_lvl : now_lvl;
      assign nxt_glitch = glitch_en_wr[g] ? (glitch_en_val[g] & glitch_pin) : glitch_ff;

      always_ff @(posedge clock) begin
        if (reset) begin
          glitch_ff <= GLITCH_EN_RST & GLITCH_PINS[g];
        end else begin
          glitch_ff <= nxt_glitch;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          prev_ff <= 1'b0;
        end else begin
          prev_ff <= now_lvl;
        end
      end

      // ======================================================
      // Digital filter
      logic [FILT_W-1:0] cnt_ff;
      logic [FILT_W-1:0] nxt_cnt;
      logic nxt_filt;
      logic differs;
      logic stable_hit;
      logic take;

      assign differs = (raw != filt_ff);
      assign stable_hit = (cnt_ff >= fconst);
      assign take = ~filt_en[g] | (differs & stable_hit);
      assign nxt_filt = take ? raw : filt_ff;
      // Count cycles while the input disagrees with the held level
      assign nxt_cnt = (take | ~differs) ? '0 : (cnt_ff + 4'h1);

      always_ff @(posedge clock) begin
        if (reset) begin
          cnt_ff <= '0;
        end else begin
          cnt_ff <= nxt_cnt;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          filt_ff <= 1'b0;
        end else begin
          filt_ff <= nxt_filt;
        end
      end

      // ======================================================
      // Peripheral inputs
      logic [NUM_FUNCS-1:0] fn_hit;
      logic [NUM_FUNCS-1:0] nxt_pin_in;
      logic [NUM_FUNCS-1:0] pin_in_ff;

      assign filt_q[g] = filt_ff & ~dig_off;
      // Only the selected function sees the pin
      assign fn_hit = 4'h1 << fsel;
      assign nxt_pin_in = fn_hit & {NUM_FUNCS{filt_q[g]}};

      always_ff @(posedge clock) begin
        if (reset) begin
          pin_in_ff <= '0;
        end else begin
          pin_in_ff <= nxt_pin_in;
        end
      end

      // ======================================================
      // Pin outputs
      assign pad_out[g] = out_ff;
      assign pad_oe_n[g] = oe_n_ff;
      assign pad_pull_up[g] = pull_up_ff;
      assign pad_pull_down[g] = pull_down_ff;
      assign pad_digital_off[g] = dig_off_ff;
      assign glitch_en[g] = glitch_ff;
      assign periph_in[g*NUM_FUNCS +: NUM_FUNCS] = pin_in_ff;

    end
  endgenerate

  // ==========================================================
  // Reset and wake in deep power-down
  logic wake_active;
  logic wake_low;
  logic nxt_chip_reset;
  logic nxt_wake;
  logic chip_reset_ff;
  logic wake_ff;

  assign wake_active = ~(wake_pin_disable & rtc_wake_en);
  assign wake_low = wake_active & ~filt_q[WAKE_PIN];
  assign nxt_chip_reset = deep_pd ? wake_low : ~rst_pin_n;
  assign nxt_wake = deep_pd & wake_low;

  always_ff @(posedge clock) begin
    if (reset) begin
      chip_reset_ff <= 1'b0;
    end else begin
      chip_reset_ff <= nxt_chip_reset;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
    end
  end

  // ==========================================================
  // Power outputs
  assign chip_reset_req = chip_reset_ff;
  assign wake_req = wake_ff;
endmodule

/* File: pfpc_pkg.sv */
package pfpc_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_PINS = 8;
  localparam int NUM_FUNCS = 4;
  localparam int FSEL_W = 2;
  localparam int FILT_W = 4;
  // ==========================================================
  // Function codes
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_ANALOG = 2'h3;
  // ==========================================================
  // Pull modes
  typedef enum logic [1:0] {
    PFPC_PULL_NONE = 2'b00,
    PFPC_PULL_DOWN = 2'b01,
    PFPC_PULL_UP = 2'b10,
    PFPC_PULL_REPEAT = 2'b11
  } pfpc_pull_e;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int GLITCH_NS = 10;
  localparam int GLITCH_CYC_RAW = (GLITCH_NS * CLK_MHZ) / 1000;
  localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int FILT_MIN_NS = 20;
  // ==========================================================
  // Reset values and pin maps
  localparam logic GLITCH_EN_RST = 1'b1;
  localparam logic [NUM_PINS-1:0] GLITCH_PINS = 8'h0F;
  localparam logic [NUM_PINS-1:0] XTAL_PINS = 8'h30;
  localparam logic [NUM_PINS-1:0] FMP_PINS = 8'hC0;
  localparam int WAKE_PIN = 0;
endpackage

/* File: pfpc_top_assertions.sv */
`timescale 1ns/10ps
// ====
// Checker
module pfpc_chk (
  input wire logic clock, reset, deep_pd, chip_reset_req, wake_req, rtc_wake_en,
  input wire logic wake_pin_disable,
  input wire logic [15:0] func_sel, pull_sel,
  input wire logic [7:0] od_en, glitch_en_wr, glitch_en_val, xtal_en, pad_in, glitch_en,
  input wire logic [7:0] filt_en, pad_out,
  input wire logic [7:0] pad_oe_n, pad_pull_up, pad_pull_down, pad_digital_off,
  input wire logic [31:0] periph_out, periph_oe, periph_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_one; $onehot0(periph_in[3:0]); endproperty
  a_one: assert property (p_one) else $error("func overlap");
  property p_ana; func_sel[1:0] == 2'h3 |=> pad_digital_off[0] && pad_oe_n[0]; endproperty
  a_ana: assert property (p_ana) else $error("analog live");
  property p_rep; pull_sel[1:0] == 2'h3 && func_sel[1:0] != 2'h3
    |=> pad_pull_up[0] && pad_pull_down[0]; endproperty
  a_rep: assert property (p_rep) else $error("repeater");
  property p_od; od_en[1] && func_sel[3:2] == 2'h0 && periph_oe[4]
    |=> pad_oe_n[1] == $past(periph_out[4]); endproperty
  a_od: assert property (p_od) else $error("open drain");
  property p_gl; glitch_en_wr[0] |=> glitch_en[0] == $past(glitch_en_val[0]) && !glitch_en[5];
  endproperty
  a_gl: assert property (p_gl) else $error("glitch");
  property p_xt; xtal_en[4] |=> pad_digital_off[4]; endproperty
  a_xt: assert property (p_xt) else $error("crystal");
  property p_fm; func_sel[13:12] == 2'h0 && periph_oe[24] && periph_out[24]
    |=> pad_oe_n[6] && !pad_out[6]; endproperty
  a_fm: assert property (p_fm) else $error("fast pin");
  property p_dp; (deep_pd && pad_in[0] && !filt_en[0] && func_sel[1:0] != 2'h3) [*8]
    |-> !chip_reset_req; endproperty
  a_dp: assert property (p_dp) else $error("deep reset");
  property p_wk; rtc_wake_en && wake_pin_disable |=> !wake_req; endproperty
  a_wk: assert property (p_wk) else $error("wake disabled");
  property p_aw; !deep_pd |=> !wake_req; endproperty
  a_aw: assert property (p_aw) else $error("wake awake");
endmodule

/* File: pfpc_pad_model.sv */
`timescale 1ns/10ps
// ====
// Pads and outside drivers
module pfpc_pad_model (
  input wire logic clock,
  input wire logic [7:0] pad_out, pad_oe_n, pad_pull_up, pad_pull_down, ext_en, ext_drv,
  output logic [7:0] pad_in
);
  logic [7:0] flt_ff = 8'h55;
  always_ff @(posedge clock) flt_ff <= ~flt_ff;
  // Chip, else outside, else pulls, else float
  assign pad_in = ~pad_oe_n & pad_out | pad_oe_n & (ext_en & ext_drv
    | ~ext_en & (pad_pull_up | 8'hC0 | ~pad_pull_down & flt_ff));
endmodule

/* File: pfpc_top_test.sv */
`timescale 1ns/10ps
// ====
// Bench
module pfpc_top_test;
  logic clock = 0, reset = 1, deep_pd = 0, rtc_wake_en = 0, wake_pin_disable = 0;
  logic reset_pin_n = 1, chip_reset_req, wake_req;
  logic [15:0] func_sel = '0, pull_sel = '0, r;
  logic [7:0] od_en = '0, glitch_en_wr = '0, glitch_en_val = '0, filt_en = '0, xtal_en = '0;
  logic [7:0] ext_en = 8'hFF, ext_drv = '0, up, dn, pad_in, pad_out, pad_oe_n, pad_pull_up;
  logic [7:0] pad_pull_down, pad_digital_off, glitch_en;
  logic [31:0] filt_const = '0, periph_out = '0, periph_oe = '0, periph_in, pick [8];
  logic [34:0] q[$], n;
  int err_total = 0, total_checks = 0, seed = 32'h05B69DDB;
  assign pick = '{periph_in, 32'(glitch_en), 32'(pad_oe_n), 32'(pad_digital_off),
    32'({pad_pull_down, pad_pull_up}), 32'(chip_reset_req), 32'(pad_out), 32'(wake_req)};
  pfpc_top uut (.*);
  pfpc_pad_model u_pad (.*);
  task automatic check(logic [31:0] seen, logic [31:0] exp_v);
    total_checks++;
    if (seen !== exp_v) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, exp_v);
    end
  endtask
  task automatic want(int c, int w, logic [31:0] v);
    repeat (c) @(posedge clock);
    q.push_back({w[2:0], v});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge clock) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      check(pick[n[34:32]], n[31:0]);
    end
  end
  initial forever #25 clock = ~clock;
  initial begin
    #50us;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clock);
    reset <= 0;
    want(1, 1, 32'h0F);
    ext_drv <= 8'h01;
    for (int f = 0; f < 4; f++) begin
      func_sel[1:0] <= f[1:0];
      want(10, 0, f == 3 ? 0 : 1 << f);
      want(0, 3, 32'(f == 3));
    end
    $display("function end");
    func_sel <= '0;
    ext_drv <= '0;
    repeat (6) begin
      r = 16'($random(seed)) | 16'h0003;
      pull_sel <= r;
      for (int i = 0; i < 8; i++) {up[i], dn[i]} = {r[2*i+1], r[2*i]};
      want(2, 4, {dn, up});
    end
    $display("pulls end");
    periph_oe <= 32'h01000010;
    for (int v = 0; v < 3; v++) begin
      od_en <= v == 2 ? 8'h00 : 8'h02;
      periph_out <= v ? 32'h01000010 : '0;
      want(2, 2, v == 0 ? 32'hBD : v == 1 ? 32'hFF : 32'hFD);
      want(0, 6, v == 2 ? 32'h02 : 32'h00);
    end
    $display("drive end");
    periph_oe <= '0;
    for (int v = 0; v < 2; v++) begin
      glitch_en_wr <= 8'hFF;
      glitch_en_val <= v ? 8'hFF : '0;
      @(posedge clock);
      glitch_en_wr <= '0;
      want(1, 1, v ? 32'h0F : '0);
    end
    $display("glitch end");
    xtal_en <= 8'hFF;
    want(2, 3, 32'h30);
    $display("crystal end");
    xtal_en <= '0;
    filt_en <= 8'h10;
    filt_const <= 32'h00040000;
    ext_drv <= 8'h10;
    repeat (3) @(posedge clock);
    ext_drv <= '0;
    want(2, 0, '0);
    want(12, 0, '0);
    ext_drv <= 8'h10;
    want(6, 0, '0);
    want(10, 0, 32'h10000);
    $display("filter end");
    deep_pd <= 1;
    reset_pin_n <= 0;
    ext_drv <= 8'h01;
    want(12, 5, '0);
    want(0, 7, '0);
    ext_drv <= '0;
    want(12, 5, 32'h1);
    want(0, 7, 32'h1);
    rtc_wake_en <= 1;
    wake_pin_disable <= 1;
    want(12, 5, '0);
    want(0, 7, '0);
    deep_pd <= 0;
    want(4, 5, 32'h1);
    reset_pin_n <= 1;
    want(4, 5, '0);
    @(posedge clock);
    $display("power end");
    wrap_up;
  end
endmodule
bind pfpc_top pfpc_chk u_chk (.*);
